// ### dv/tb_top.sv
// self-checking bench for the thermal result registers
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned M = 4;
  logic        ref_clk, rst_n, reg_wr, reg_rd, conv_busy_q, conv_start_q, standby_q;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, got;
  logic [9:0]  local_code;
  logic [11:0] remote1_code, remote2_code;
  int          error_cnt = 0, num_checks = 0, starts = 0, cyc = 0, last_st = 0, gap = 0, t0;
  logic [7:0]  cfg_v [2] = '{8'h44, 8'h42};
  logic [7:0]  exp_v [2][4] = '{'{8'h00, 8'h00, 8'h7F, 8'hE0}, '{8'hFC, 8'h80, 8'hC8, 8'hA0}};
  int          rate_ms [4] = '{66, 200, 1000, 3000};
  tr_result_regs #(.MS_CYCLES(M), .MAKER_ID(8'h5A), .DIE_REV(8'h03)) u_tr_result_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .local_code(local_code), .remote1_code(remote1_code), .remote2_code(remote2_code),
    .reg_rdata_q(reg_rdata_q), .conv_busy_q(conv_busy_q), .conv_start_q(conv_start_q), .standby_q(standby_q));
  tr_host_model u_tr_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // pre-edge sample of the start pulse, spacing kept in cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (conv_start_q === 1'b1) begin
      gap = cyc - last_st;
      last_st = cyc;
      starts++;
    end
  end
  task finish_test;
    $display("COUNTS: checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    u_tr_host_model.rd(a, got);
    chk($sformatf("reg %0h", a), {24'h000000, e}, {24'h000000, got});
  endtask
  task wait_start(input int n);
    int t;
    t = starts + n;
    // two starts at the slowest rate need about 24000 cycles at M = 4
    for (int i = 0; i < 26000 && starts < t; i++) @(negedge ref_clk);
    chk("start seen", 1, starts >= t);
  endtask
  task wait_idle;
    for (int i = 0; i < 400 && conv_busy_q !== 1'b0; i++) @(negedge ref_clk);
    chk("idle", 0, {31'h0, conv_busy_q});
  endtask
  task one_shot;
    u_tr_host_model.wr(8'h0F, 8'hA5);
    wait_start(1);
    rdc(8'h02, 8'h80);
    wait_idle;
  endtask
  initial begin
    rst_n = 1'b0;
    local_code = 10'h3F6;
    remote1_code = 12'hFE4;
    remote2_code = 12'h645;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    rdc(8'h03, 8'h00);
    u_tr_host_model.wr(8'h03, 8'hFF);
    rdc(8'h03, 8'h76);
    chk("standby", 1, {31'h0, standby_q});
    rdc(8'hFE, 8'h5A);
    rdc(8'hFF, 8'h03);
    rdc(8'h0F, 8'h00);
    rdc(8'h55, 8'h00);
    wait_idle;
    t0 = starts;
    repeat (400) @(negedge ref_clk);
    chk("starts in standby", t0, starts);
    for (int k = 0; k < 2; k++) begin
      u_tr_host_model.wr(8'h03, cfg_v[k]);
      one_shot;
      rdc(8'h10, 8'hFD);
      rdc(8'h20, 8'h80);
      rdc(8'h11, exp_v[k][0]);
      rdc(8'h21, exp_v[k][1]);
      rdc(8'h12, exp_v[k][2]);
      rdc(8'h22, exp_v[k][3]);
    end
    rdc(8'h11, 8'hFC);
    remote1_code = 12'h0C8;
    one_shot;
    rdc(8'h21, 8'h80);
    rdc(8'h21, 8'h00);
    rdc(8'h11, 8'h19);
    remote1_code = 12'h0CD;
    one_shot;
    rdc(8'h11, 8'h19);
    rdc(8'h21, 8'hA0);
    for (int r = 0; r < 4; r++) begin
      u_tr_host_model.wr(8'h03, {2'b00, r[1:0], 4'h0});
      wait_start(2);
      chk("interval", 1, gap >= rate_ms[r] * M && gap <= rate_ms[r] * M + M + 2);
    end
    chk("standby cleared", 0, {31'h0, standby_q});
    finish_test;
  end
  // every rate interval twice over, plus the one-shot passes
  initial begin
    #(60000 * 40);
    error_cnt++;
    finish_test;
  end
endmodule

// ### dv/tr_host_model.sv
// host side of the register port, one strobe per byte
`timescale 1ns/1ns
module tr_host_model (
  input  wire logic       ref_clk,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // released lines inverted so a stale value cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

// ### dv/tr_result_regs_assertions.sv
// port assertions for the thermal result registers
`timescale 1ns/1ns
module tr_result_regs_assertions #(
  parameter int unsigned MS_CYCLES = 25000,
  parameter logic [7:0]  MAKER_ID  = 8'h00,
  parameter logic [7:0]  DIE_REV   = 8'h00
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [9:0]  local_code,
  input wire logic [11:0] remote1_code,
  input wire logic [11:0] remote2_code,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        conv_busy_q,
  input wire logic        conv_start_q,
  input wire logic        standby_q
);
  localparam int unsigned BUSY_LO = 66 * MS_CYCLES;
  localparam int unsigned BUSY_HI = 66 * MS_CYCLES + MS_CYCLES + 2;
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // busy length counted here, too long for a repetition; 32 bits cover the full-rate span
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_q <= 32'h00000000;
    else
      busy_cnt_q <= conv_busy_q ? busy_cnt_q + 32'h00000001 : 32'h00000000;
  end
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  cfg_rsvd_a: assert property (rd_at(8'h03) |=> (reg_rdata_q & 8'h89) == 8'h00)
    else $error("config reserved bits read nonzero");
  halt_copy_a: assert property (reg_wr && reg_addr == 8'h03 |=> standby_q == $past(reg_wdata[6]))
    else $error("standby does not follow halt bit");
  busy_len_a: assert property ($fell(conv_busy_q) |-> busy_cnt_q >= BUSY_LO && busy_cnt_q <= BUSY_HI)
    else $error("conversion cycle length wrong");
  one_shot_rd_a: assert property (rd_at(8'h0F) |=> reg_rdata_q == 8'h00)
    else $error("one-shot location reads nonzero");
  remote_low_a: assert property (reg_rd && reg_addr inside {8'h21, 8'h22} |=> reg_rdata_q[4:0] == 5'h00)
    else $error("remote low byte unused bits set");
  local_low_a: assert property (rd_at(8'h20) |=> reg_rdata_q[5:0] == 6'h00)
    else $error("local low byte unused bits set");
  maker_id_a: assert property (rd_at(8'hFE) |=> reg_rdata_q == MAKER_ID)
    else $error("maker identity wrong");
  die_rev_a: assert property (rd_at(8'hFF) |=> reg_rdata_q == DIE_REV)
    else $error("die revision wrong");
  status_bits_a: assert property (rd_at(8'h02) |=> reg_rdata_q[6:0] == 7'h00)
    else $error("status reserved bits set");
  start_busy_a: assert property (conv_start_q |-> conv_busy_q ##1 !conv_start_q)
    else $error("start pulse without busy or too long");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
endmodule

bind tr_result_regs tr_result_regs_assertions #(.MS_CYCLES(MS_CYCLES), .MAKER_ID(MAKER_ID), .DIE_REV(DIE_REV)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .local_code(local_code), .remote1_code(remote1_code), .remote2_code(remote2_code),
  .reg_rdata_q(reg_rdata_q), .conv_busy_q(conv_busy_q), .conv_start_q(conv_start_q), .standby_q(standby_q));

// ### logic/tr_defines.svh
// timing counts, command codes, field positions and reset values of the thermal result registers
`ifndef TR_DEFINES_SVH
`define TR_DEFINES_SVH

// clock rate in kHz, so one millisecond is this many cycles
`define TR_CLK_KHZ        25000

// conversion intervals and channel conversion times, in ms
`define TR_RATE0_MS       66
`define TR_RATE1_MS       200
`define TR_RATE2_MS       1000
`define TR_RATE3_MS       3000
`define TR_LOCAL_CONV_MS  14
`define TR_REMOTE_CONV_MS 26

// command codes
`define TR_CMD_STATUS     8'h02
`define TR_CMD_CONFIG     8'h03
`define TR_CMD_ONE_SHOT   8'h0F
`define TR_CMD_LOCAL_HI   8'h10
`define TR_CMD_REM1_HI    8'h11
`define TR_CMD_REM2_HI    8'h12
`define TR_CMD_LOCAL_LO   8'h20
`define TR_CMD_REM1_LO    8'h21
`define TR_CMD_REM2_LO    8'h22
`define TR_CMD_MAKER_ID   8'hFE
`define TR_CMD_DIE_REV    8'hFF

// configuration fields
`define TR_CFG_HALT_BIT   6
`define TR_CFG_RATE_HI    5
`define TR_CFG_RATE_LO    4
`define TR_CFG_FMT2_BIT   2
`define TR_CFG_FMT1_BIT   1
`define TR_CFG_WR_MASK    8'h76
`define TR_CFG_RESET      8'h00

// status fields
`define TR_STAT_BUSY_BIT  7

// interval timer start value, forces a first cycle right after reset
`define TR_IVAL_RESET     12'hFFF

`endif

// ### logic/tr_ms_tick.sv
// millisecond enable divider with synchronous restart
`timescale 1ns/1ns
module tr_ms_tick #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic          wrap;

  assign wrap = (cnt_q == LAST);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      // restart aligns the first ms of a cycle to its start
      cnt_q <= (restart || wrap) ? '0 : cnt_q + 1'b1;
      tick  <= wrap && !restart;
    end
  end

endmodule

// ### logic/tr_pkg.sv
// types shared by the thermal result register logic
package tr_pkg;

  typedef enum logic [3:0] {
    TR_IDLE   = 4'b0001,
    TR_LOCAL  = 4'b0010,
    TR_REMOTE1 = 4'b0100,
    TR_REMOTE2 = 4'b1000
  } tr_state_t;

  typedef logic [11:0] tr_ms_t;

endpackage

// ### logic/tr_result_regs.sv
// configuration, conversion sequencing and result registers of the thermal sensor
//
// Function
// - configuration register read/write at 03h
// - config bits 7, 3, 0 read zero
// - halt bit stops periodic conversions, standby
// - one-shot write in standby starts cycle
// - rate field picks 66ms/200ms/1s/3s interval
// - remote takes 26 ms, local 14 ms
// - format bits pick unsigned or signed remote
// - configuration resets to all zeros
// - remote high bytes hold whole degrees
// - remote low byte: three fraction bits
// - high read freezes that channel's low byte
// - low byte read releases the freeze
// - each high read recaptures low byte
// - FEh returns fixed maker identity byte
// - FFh returns die revision code
// - one-shot location stores nothing, reads zero
// - every cycle converts all three channels
// - status bit 7 shows conversion busy
// - unused low-byte bits read zero
`timescale 1ns/1ns
`include "tr_defines.svh"
module tr_result_regs
  import tr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `TR_CLK_KHZ,
  // arbitrary identity values
  parameter logic [7:0]  MAKER_ID  = 8'h5A,
  parameter logic [7:0]  DIE_REV   = 8'h03
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic [9:0]  local_code,
  input  wire logic [11:0] remote1_code,
  input  wire logic [11:0] remote2_code,
  output logic [7:0]       reg_rdata_q,
  output logic             conv_busy_q,
  output logic             conv_start_q,
  output logic             standby_q
);

  localparam tr_ms_t LOCAL_MS  = tr_ms_t'(`TR_LOCAL_CONV_MS);
  localparam tr_ms_t REMOTE_MS = tr_ms_t'(`TR_REMOTE_CONV_MS);

  // clamp a 1/8-degree code into the 11-bit register range of the selected format
  function automatic logic [10:0] fmt_remote(input logic [11:0] code, input logic signed_fmt);
    logic [10:0] r;
    r = code[10:0];
    if (signed_fmt) begin
      if (code[11] != code[10]) begin
        r = code[11] ? 11'h400 : 11'h3FF;
      end
    end else if (code[11]) begin
      r = 11'h000;
    end
    return r;
  endfunction

  function automatic tr_ms_t rate_interval(input logic [1:0] rate);
    tr_ms_t r;
    case (rate)
      2'b00:   r = tr_ms_t'(`TR_RATE0_MS);
      2'b01:   r = tr_ms_t'(`TR_RATE1_MS);
      2'b10:   r = tr_ms_t'(`TR_RATE2_MS);
      default: r = tr_ms_t'(`TR_RATE3_MS);
    endcase
    return r;
  endfunction

  logic [7:0]  cfg_q;
  tr_state_t   state_q;
  tr_state_t   state_d;
  tr_ms_t      phase_q;
  tr_ms_t      ival_q;
  logic        oneshot_q;
  logic [9:0]  local_res_q;
  logic [10:0] rem1_res_q;
  logic [10:0] rem2_res_q;
  logic [2:0]  lock_q;
  logic [7:0]  frozen_q [3];

  logic        ms_tick;
  logic        halt;
  logic        idle;
  logic        interval_hit;
  logic        start_cycle;
  tr_ms_t      phase_len;
  logic        phase_done;
  logic        wr_cfg;
  logic        wr_oneshot;
  logic [2:0]  rd_hi;
  logic [2:0]  rd_lo;
  logic [7:0]  live_lo [3];
  logic [7:0]  shown_lo [3];
  logic [7:0]  status_val;
  logic [7:0]  rd_val;

  tr_ms_tick #(
    .DIV (MS_CYCLES)
  ) u_ms_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (start_cycle),
    .tick    (ms_tick)
  );

  assign halt = cfg_q[`TR_CFG_HALT_BIT];
  assign idle = (state_q == TR_IDLE);

  // ---- register port decode ----
  assign wr_cfg     = reg_wr && (reg_addr == `TR_CMD_CONFIG);
  assign wr_oneshot = reg_wr && (reg_addr == `TR_CMD_ONE_SHOT);
  assign rd_hi      = {reg_rd && (reg_addr == `TR_CMD_REM2_HI),
                       reg_rd && (reg_addr == `TR_CMD_REM1_HI),
                       reg_rd && (reg_addr == `TR_CMD_LOCAL_HI)};
  assign rd_lo      = {reg_rd && (reg_addr == `TR_CMD_REM2_LO),
                       reg_rd && (reg_addr == `TR_CMD_REM1_LO),
                       reg_rd && (reg_addr == `TR_CMD_LOCAL_LO)};

  // ---- sequencing ----
  // interval from rate
  assign interval_hit = (ival_q >= rate_interval(cfg_q[`TR_CFG_RATE_HI:`TR_CFG_RATE_LO]));
  assign start_cycle  = idle && (halt ? oneshot_q : interval_hit);
  assign phase_len    = (state_q == TR_LOCAL) ? LOCAL_MS : REMOTE_MS;
  assign phase_done   = !idle && ms_tick && (phase_q == phase_len - 1'b1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      TR_IDLE: begin
        if (start_cycle) begin
          state_d = TR_LOCAL;
        end
      end
      TR_LOCAL: begin
        if (phase_done) begin
          state_d = TR_REMOTE1;
        end
      end
      TR_REMOTE1: begin
        if (phase_done) begin
          state_d = TR_REMOTE2;
        end
      end
      TR_REMOTE2: begin
        // back to idle after one cycle
        if (phase_done) begin
          state_d = TR_IDLE;
        end
      end
      default: begin
        state_d = TR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TR_IDLE;
      phase_q <= '0;
    end else begin
      state_q <= state_d;
      phase_q <= (start_cycle || phase_done) ? '0 : phase_q + tr_ms_t'(ms_tick);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ival_q <= `TR_IVAL_RESET;
    end else if (start_cycle) begin
      ival_q <= '0;
    end else if (ms_tick && (ival_q != `TR_IVAL_RESET)) begin
      ival_q <= ival_q + 1'b1;
    end
  end

  // a one-shot written mid-cycle waits for idle rather than being lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oneshot_q <= 1'b0;
    end else if (wr_oneshot && halt) begin
      oneshot_q <= 1'b1;
    end else if (start_cycle || !halt) begin
      oneshot_q <= 1'b0;
    end
  end

  // ---- configuration ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `TR_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata & `TR_CFG_WR_MASK;
    end
  end

  // ---- results ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_res_q <= '0;
      rem1_res_q  <= '0;
      rem2_res_q  <= '0;
    end else if (phase_done) begin
      if (state_q == TR_LOCAL) begin
        local_res_q <= local_code;
      end
      if (state_q == TR_REMOTE1) begin
        rem1_res_q <= fmt_remote(remote1_code, cfg_q[`TR_CFG_FMT1_BIT]);
      end
      if (state_q == TR_REMOTE2) begin
        rem2_res_q <= fmt_remote(remote2_code, cfg_q[`TR_CFG_FMT2_BIT]);
      end
    end
  end

  assign live_lo[0] = {local_res_q[1:0], 6'h00};
  assign live_lo[1] = {rem1_res_q[2:0], 5'h00};
  assign live_lo[2] = {rem2_res_q[2:0], 5'h00};

  // ---- coherent high/low pairs ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= '0;
      for (int i = 0; i < 3; i++) begin
        frozen_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (rd_hi[i]) begin
          lock_q[i]   <= 1'b1;
          frozen_q[i] <= live_lo[i];
        end else if (rd_lo[i]) begin
          lock_q[i] <= 1'b0;
        end
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_shown
    assign shown_lo[g] = lock_q[g] ? frozen_q[g] : live_lo[g];
  end

  assign status_val = {!idle, 7'h00};

  assign rd_val =
    (reg_addr == `TR_CMD_STATUS)   ? status_val            :
    (reg_addr == `TR_CMD_CONFIG)   ? cfg_q                 :
    (reg_addr == `TR_CMD_LOCAL_HI) ? local_res_q[9:2]      :
    (reg_addr == `TR_CMD_REM1_HI)  ? rem1_res_q[10:3]      :
    (reg_addr == `TR_CMD_REM2_HI)  ? rem2_res_q[10:3]      :
    (reg_addr == `TR_CMD_LOCAL_LO) ? shown_lo[0]           :
    (reg_addr == `TR_CMD_REM1_LO)  ? shown_lo[1]           :
    (reg_addr == `TR_CMD_REM2_LO)  ? shown_lo[2]           :
    (reg_addr == `TR_CMD_MAKER_ID) ? MAKER_ID              :
    (reg_addr == `TR_CMD_DIE_REV)  ? DIE_REV               :
                                     8'h00;

  // ---- outputs ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q  <= 8'h00;
      conv_busy_q  <= 1'b0;
      conv_start_q <= 1'b0;
      standby_q    <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata_q <= rd_val;
      end
      conv_busy_q  <= (state_d != TR_IDLE);
      conv_start_q <= start_cycle;
      standby_q    <= (wr_cfg ? reg_wdata[`TR_CFG_HALT_BIT] : halt);
    end
  end

endmodule
